// [pkg/oosc_pkg.sv]
// package for the on/off state controller: states, codes and timing counts
`default_nettype none
package oosc_pkg;
  // controller states
  typedef enum logic [3:0] {
    ST_NOPWR    = 4'h0,
    ST_SETTLE   = 4'h1,
    ST_STANDBY  = 4'h2,
    ST_SWON     = 4'h3,
    ST_WAITBOK  = 4'h4,
    ST_PWRUP    = 4'h5,
    ST_HOLDWAIT = 4'h6,
    ST_ON       = 4'h7,
    ST_PWRDN    = 4'h8,
    ST_BIASOFF  = 4'h9
  } oosc_state_t;
  // software reset field codes
  localparam logic [1:0] SRST_NONE = 2'h0;
  localparam logic [1:0] SRST_COLD = 2'h1;
  localparam logic [1:0] SRST_OFF = 2'h2;
  // clock rate
  localparam int CLK_HZ = 20000000;
  // charger input debounce time, in ms
  localparam int CHG_DB_MS = 120;
  localparam int CHG_DB_CYC = CHG_DB_MS * (CLK_HZ / 1000);
  // settle time after supply is good, in us (plain choice)
  localparam int SETTLE_US = 10;
  localparam int SETTLE_CYC = (SETTLE_US * (CLK_HZ / 1000000) > 0) ?
    SETTLE_US * (CLK_HZ / 1000000) : 1;
  // hold wait time, in ms (plain choice)
  localparam int HOLD_WAIT_MS = 1;
  localparam int HOLD_WAIT_CYC = HOLD_WAIT_MS * (CLK_HZ / 1000);
  // counter width
  localparam int CNT_W = 24;
  // number of flexible sequencer slots
  localparam int FLEX_SLOTS = 4;
endpackage
`default_nettype wire

// [hw/oosc_ctrl.sv]
// on/off state controller of a power-management device
//
// Function
// - stay powered off while supply below threshold
// - settle, release internal reset, go standby
// - standby waits for wake or bias enable
// - standby keeps bias and peripherals off
// - bias enable set moves standby to software-on
// - bias enable cleared returns to standby
// - debounced onkey falling edge is a wake
// - debounced charger rising edge is a wake
// - software code 01 sets wake flag
// - wait for bias ok before power-up
// - after power-up, time hold wait period
// - hold expired and low: power down
// - keep waiting; hold high enters on
// - on state enables all flex slots
// - on state keeps main bias enabled
// - cold reset code starts power-down
// - power-off code starts power-down
// - overtemperature lockout forces power-down in on state only
// - undervoltage lockout forces power-down in on state only
// - leave power-down only when sequence done or supply lost
// - then disable bias and return standby
// - overvoltage lockout only acts in on state
`default_nettype none
module oosc_ctrl #(
  parameter int CHG_DB_CYC = oosc_pkg::CHG_DB_CYC,
  parameter int HOLD_WAIT_CYC = oosc_pkg::HOLD_WAIT_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic supply_good, // supply above power-on-reset threshold
  input wire logic bias_enable, // software bias enable bit
  input wire logic onkey_n, // onkey pin, active low, raw
  input wire logic onkey_debounced, // debounced onkey level, active low
  input wire logic charger_input, // charger present, raw
  input wire logic [1:0] software_reset_code, // software reset field
  input wire logic software_reset_wr, // one-cycle write strobe of the field
  input wire logic bias_ok, // main bias ok
  input wire logic pwrup_done, // power-up sequence complete
  input wire logic pwrdn_done, // power-down sequence complete
  input wire logic bias_off_done, // main bias disabled
  input wire logic hold_input, // hold pin
  input wire logic otlo, // overtemperature lockout
  input wire logic uvlo, // undervoltage lockout
  input wire logic ovlo, // overvoltage lockout
  output logic internal_rst, // internal reset, high until settled
  output logic main_bias_en, // main bias on
  output logic periph_allow, // peripherals may operate
  output logic [oosc_pkg::FLEX_SLOTS-1:0] flex_sequencer, // slot enables
  output logic pwrup_start, // power-up sequence running
  output logic pwrdn_start, // power-down sequence running
  output logic wake_flag, // internal wake flag
  output logic [3:0] state // current state code
);
  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; the first stage feeds only the second
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic supply_s;
  logic onkey_s;
  logic chg_s;
  // synchronise supply, debounced onkey and charger input
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_r <= 3'h2;
      sync2_r <= 3'h2;
    end else begin
      sync1_r <= {charger_input, onkey_debounced, supply_good};
      sync2_r <= sync1_r;
    end
  end
  assign supply_s = sync2_r[0];
  assign onkey_s = sync2_r[1];
  assign chg_s = sync2_r[2];

  //////////////////////////////////////////////////////////////////////////////
  oosc_pkg::oosc_state_t st_r;
  oosc_pkg::oosc_state_t st_nxt;
  logic onkey_d_r; // previous onkey level
  logic onkey_fall; // falling edge of debounced onkey
  logic chg_d_r; // previous charger level
  logic [oosc_pkg::CNT_W-1:0] chg_cnt_r; // charger debounce count
  logic chg_wake_r; // debounced charger rising edge
  logic [oosc_pkg::CNT_W-1:0] tmr_r; // settle and hold wait timer
  logic tmr_done;
  logic wake_r;
  logic wake_any;
  logic exit_req;
  logic in_run;

  // onkey edge; raw pin is unused beyond its debounced status
  always_ff @(posedge clk) begin
    if (rst) begin
      onkey_d_r <= 1'b1;
    end else begin
      onkey_d_r <= onkey_s;
    end
  end
  assign onkey_fall = onkey_d_r & ~onkey_s;

  // charger: rising edge arms a counter; level must hold the full time
  always_ff @(posedge clk) begin
    if (rst) begin
      chg_d_r <= 1'b0;
      chg_cnt_r <= '0;
      chg_wake_r <= 1'b0;
    end else begin
      chg_d_r <= chg_s;
      chg_wake_r <= 1'b0;
      if (!chg_s) begin
        chg_cnt_r <= '0;
      end else if (chg_s && !chg_d_r) begin
        chg_cnt_r <= oosc_pkg::CNT_W'(1);
      end else if (chg_cnt_r != '0) begin
        if (chg_cnt_r == oosc_pkg::CNT_W'(CHG_DB_CYC)) begin
          chg_wake_r <= 1'b1;
          chg_cnt_r <= '0;
        end else begin
          chg_cnt_r <= chg_cnt_r + oosc_pkg::CNT_W'(1);
        end
      end
    end
  end

  // wake flag from software code 01; consumed when the wake is taken
  always_ff @(posedge clk) begin
    if (rst || !supply_s) begin
      wake_r <= 1'b0;
    end else if (software_reset_wr && software_reset_code == oosc_pkg::SRST_COLD) begin
      wake_r <= 1'b1;
    end else if (st_r == oosc_pkg::ST_STANDBY && st_nxt == oosc_pkg::ST_WAITBOK) begin
      wake_r <= 1'b0;
    end
  end
  assign wake_any = onkey_fall | chg_wake_r | wake_r;

  // on-state exit conditions; ovlo is only looked at here
  assign exit_req = ~hold_input | otlo | uvlo | ovlo
    | (software_reset_wr & (software_reset_code == oosc_pkg::SRST_COLD))
    | (software_reset_wr & (software_reset_code == oosc_pkg::SRST_OFF));

  //////////////////////////////////////////////////////////////////////////////
  // timer for settle and hold wait; restarts on each state change
  always_ff @(posedge clk) begin
    if (rst || st_nxt != st_r) begin
      tmr_r <= '0;
    end else if (!tmr_done) begin
      tmr_r <= tmr_r + oosc_pkg::CNT_W'(1);
    end
  end
  always_comb begin
    if (st_r == oosc_pkg::ST_SETTLE) begin
      tmr_done = tmr_r >= oosc_pkg::CNT_W'(oosc_pkg::SETTLE_CYC);
    end else begin
      tmr_done = tmr_r >= oosc_pkg::CNT_W'(HOLD_WAIT_CYC);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      oosc_pkg::ST_NOPWR: begin
        if (supply_s) st_nxt = oosc_pkg::ST_SETTLE;
      end
      oosc_pkg::ST_SETTLE: begin
        if (tmr_done) st_nxt = oosc_pkg::ST_STANDBY;
      end
      oosc_pkg::ST_STANDBY: begin
        if (wake_any) st_nxt = oosc_pkg::ST_WAITBOK;
        else if (bias_enable) st_nxt = oosc_pkg::ST_SWON;
      end
      oosc_pkg::ST_SWON: begin
        if (!bias_enable) st_nxt = oosc_pkg::ST_STANDBY;
      end
      oosc_pkg::ST_WAITBOK: begin
        if (bias_ok) st_nxt = oosc_pkg::ST_PWRUP;
      end
      oosc_pkg::ST_PWRUP: begin
        if (pwrup_done) st_nxt = oosc_pkg::ST_HOLDWAIT;
      end
      oosc_pkg::ST_HOLDWAIT: begin
        if (hold_input) st_nxt = oosc_pkg::ST_ON;
        else if (tmr_done) st_nxt = oosc_pkg::ST_PWRDN;
      end
      oosc_pkg::ST_ON: begin
        if (exit_req) st_nxt = oosc_pkg::ST_PWRDN;
      end
      oosc_pkg::ST_PWRDN: begin
        if (pwrdn_done) st_nxt = oosc_pkg::ST_BIASOFF;
      end
      oosc_pkg::ST_BIASOFF: begin
        if (bias_off_done) st_nxt = oosc_pkg::ST_STANDBY;
      end
      default: st_nxt = oosc_pkg::ST_NOPWR;
    endcase
    if (!supply_s) st_nxt = oosc_pkg::ST_NOPWR;
  end

  // state register; supply loss wins over everything else
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= oosc_pkg::ST_NOPWR;
    end else begin
      st_r <= st_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs, registered from the next state
  assign in_run = (st_nxt == oosc_pkg::ST_ON);
  always_ff @(posedge clk) begin
    if (rst) begin
      internal_rst <= 1'b1;
      main_bias_en <= 1'b0;
      periph_allow <= 1'b0;
      flex_sequencer <= '0;
      pwrup_start <= 1'b0;
      pwrdn_start <= 1'b0;
    end else begin
      internal_rst <= (st_nxt == oosc_pkg::ST_NOPWR) || (st_nxt == oosc_pkg::ST_SETTLE);
      // bias stays off in standby and off states; it drops while it is shut down,
      // since the far side can only report it disabled once we stop asking for it
      main_bias_en <= !(st_nxt == oosc_pkg::ST_NOPWR || st_nxt == oosc_pkg::ST_SETTLE
        || st_nxt == oosc_pkg::ST_STANDBY
        || st_nxt == oosc_pkg::ST_BIASOFF);
      periph_allow <= (st_nxt == oosc_pkg::ST_SWON) || in_run;
      flex_sequencer <= {oosc_pkg::FLEX_SLOTS{in_run}};
      pwrup_start <= (st_nxt == oosc_pkg::ST_PWRUP);
      pwrdn_start <= (st_nxt == oosc_pkg::ST_PWRDN);
    end
  end
  assign wake_flag = wake_r;
  assign state = st_r;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_enter_on;
    st_r == oosc_pkg::ST_HOLDWAIT && hold_input && supply_s;
  endsequence
  sequence s_enter_dn;
    st_r == oosc_pkg::ST_ON && exit_req && supply_s;
  endsequence

  a_supply_loss: assert property (@(posedge clk) disable iff (rst)
    !supply_s |=> st_r == oosc_pkg::ST_NOPWR) else $error("supply loss not honoured");
  a_standby_bias: assert property (@(posedge clk) disable iff (rst)
    st_r == oosc_pkg::ST_STANDBY && $past(st_r) == oosc_pkg::ST_STANDBY |-> !main_bias_en
    && !periph_allow) else $error("bias on in standby");
  a_swon_entry: assert property (@(posedge clk) disable iff (rst)
    st_r == oosc_pkg::ST_STANDBY && supply_s && !wake_any && bias_enable
    |=> st_r == oosc_pkg::ST_SWON) else $error("no software-on");
  a_swon_exit: assert property (@(posedge clk) disable iff (rst)
    st_r == oosc_pkg::ST_SWON && supply_s && !bias_enable
    |=> st_r == oosc_pkg::ST_STANDBY) else $error("no return to standby");
  a_wait_bok: assert property (@(posedge clk) disable iff (rst)
    st_r == oosc_pkg::ST_WAITBOK && !bias_ok |=> st_r != oosc_pkg::ST_PWRUP)
    else $error("power-up without bias ok");
  a_on_outputs: assert property (@(posedge clk) disable iff (rst)
    s_enter_on |=> st_r == oosc_pkg::ST_ON && (&flex_sequencer) && main_bias_en)
    else $error("on state outputs wrong");
  a_down_single: assert property (@(posedge clk) disable iff (rst)
    s_enter_dn |=> st_r == oosc_pkg::ST_PWRDN ##1 (st_r == oosc_pkg::ST_PWRDN
    || st_r == oosc_pkg::ST_BIASOFF || st_r == oosc_pkg::ST_NOPWR))
    else $error("power-down path broken");
  a_hold_timeout: assert property (@(posedge clk) disable iff (rst)
    st_r == oosc_pkg::ST_HOLDWAIT && !hold_input && tmr_done && supply_s
    |=> st_r == oosc_pkg::ST_PWRDN) else $error("hold timeout missed");
  a_pwrdn_hold: assert property (@(posedge clk) disable iff (rst)
    st_r == oosc_pkg::ST_PWRDN && !pwrdn_done && supply_s |=> st_r == oosc_pkg::ST_PWRDN)
    else $error("left power-down early");
  // hold pin low and time left: the controller must not give up early
  a_hold_wait: assert property (@(posedge clk) disable iff (rst)
    st_r == oosc_pkg::ST_HOLDWAIT && !hold_input && !tmr_done && supply_s
    |=> st_r == oosc_pkg::ST_HOLDWAIT) else $error("hold wait cut short");
  // settle keeps the internal reset up until the timer runs out
  a_settle_rst: assert property (@(posedge clk) disable iff (rst)
    st_r == oosc_pkg::ST_SETTLE && !tmr_done && supply_s
    |=> st_r == oosc_pkg::ST_SETTLE && internal_rst) else $error("settle released early");
  // bias is dropped on the way back to standby
  a_bias_off: assert property (@(posedge clk) disable iff (rst)
    st_r == oosc_pkg::ST_BIASOFF && bias_off_done && supply_s
    |=> st_r == oosc_pkg::ST_STANDBY && !main_bias_en) else $error("bias not dropped");
  // overvoltage has no say over the software-on state
  a_swon_ovlo: assert property (@(posedge clk) disable iff (rst)
    st_r == oosc_pkg::ST_SWON && bias_enable && supply_s
    |=> st_r == oosc_pkg::ST_SWON) else $error("software-on left unasked");
  // an overtemperature or undervoltage lockout in the on state starts the power-down path while supply is good
  a_lockout_exit: assert property (@(posedge clk) disable iff (rst)
    st_r == oosc_pkg::ST_ON && (otlo || uvlo) && supply_s
    |=> st_r == oosc_pkg::ST_PWRDN) else $error("lockout ignored");
  // power-off code in the on state starts the power-down path
  a_code_off: assert property (@(posedge clk) disable iff (rst)
    st_r == oosc_pkg::ST_ON && software_reset_wr && supply_s
    && software_reset_code == oosc_pkg::SRST_OFF
    |=> st_r == oosc_pkg::ST_PWRDN) else $error("power-off code ignored");
  // a write of code 01 sets the wake flag even if it is consumed in the same cycle
  a_wake_set: assert property (@(posedge clk) disable iff (rst)
    software_reset_wr && software_reset_code == oosc_pkg::SRST_COLD && supply_s
    |=> wake_r) else $error("wake flag not set");
endmodule
`default_nettype wire

// [verification/oosc_far_side.sv]
// far-side model: analog bias and sequencer answering the controller
`default_nettype none
module oosc_far_side (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] state,
  input wire logic main_bias_en,
  input wire logic pwrup_start,
  input wire logic pwrdn_start,
  input wire logic [7:0] lat,
  output logic bias_ok,
  output logic pwrup_done,
  output logic pwrdn_done,
  output logic bias_off_done
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] seen_r; // state one edge ago
  logic [7:0] age_r; // cycles spent in this state
  logic ripe; // answer delay used up; never ripe on the entry cycle
  //////////////////////////////////////////////////////////////////
  // age restarts on every state change so each request waits afresh
  always_ff @(posedge clk) begin
    seen_r <= state;
    if (rst || state != seen_r) age_r <= 8'h00;
    else if (age_r != 8'hff) age_r <= age_r + 8'h01;
  end
  assign ripe = (state == seen_r) && (age_r >= lat);
  assign bias_ok = main_bias_en && (state != oosc_pkg::ST_WAITBOK || ripe);
  assign pwrup_done = pwrup_start && ripe;
  assign pwrdn_done = pwrdn_start && ripe;
  assign bias_off_done = (state == oosc_pkg::ST_BIASOFF) && !main_bias_en && ripe;
endmodule
`default_nettype wire

// [verification/test_on_off_state_controller.sv]
// self-checking bench for the on/off state controller
`default_nettype none
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin fails++; \
  $display("BAD %s expected %h seen %h", nm, ex, gt); end end
module test_on_off_state_controller;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DB_CYC = 8; // shortened charger debounce
  localparam int HOLD_CYC = 10; // shortened hold wait
  logic clk, rst, supply_good, bias_enable, onkey_n, onkey_debounced, charger_input;
  logic [1:0] software_reset_code;
  logic software_reset_wr, bias_ok, pwrup_done, pwrdn_done, bias_off_done;
  logic hold_input, otlo, uvlo, ovlo, internal_rst, main_bias_en, periph_allow;
  logic [oosc_pkg::FLEX_SLOTS-1:0] flex_sequencer;
  logic pwrup_start, pwrdn_start, wake_flag;
  logic [3:0] state, prev_s, exp_s;
  logic [7:0] lat; // far-side answer delay
  logic [3:0] expq[$]; // states owed by the design, oldest first
  int fails = 0;
  int compares = 0;
  oosc_ctrl #(.CHG_DB_CYC(DB_CYC), .HOLD_WAIT_CYC(HOLD_CYC)) dut (
    .clk(clk), .rst(rst), .supply_good(supply_good), .bias_enable(bias_enable),
    .onkey_n(onkey_n), .onkey_debounced(onkey_debounced), .charger_input(charger_input),
    .software_reset_code(software_reset_code), .software_reset_wr(software_reset_wr),
    .bias_ok(bias_ok), .pwrup_done(pwrup_done), .pwrdn_done(pwrdn_done),
    .bias_off_done(bias_off_done), .hold_input(hold_input), .otlo(otlo), .uvlo(uvlo),
    .ovlo(ovlo), .internal_rst(internal_rst), .main_bias_en(main_bias_en),
    .periph_allow(periph_allow), .flex_sequencer(flex_sequencer),
    .pwrup_start(pwrup_start), .pwrdn_start(pwrdn_start), .wake_flag(wake_flag),
    .state(state));
  oosc_far_side far (.clk(clk), .rst(rst), .state(state), .main_bias_en(main_bias_en),
    .pwrup_start(pwrup_start), .pwrdn_start(pwrdn_start), .lat(lat), .bias_ok(bias_ok),
    .pwrup_done(pwrup_done), .pwrdn_done(pwrdn_done), .bias_off_done(bias_off_done));
  //////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // every state change takes the oldest note; an unowed change fails
  always @(posedge clk) begin
    if (!rst && state !== prev_s) begin
      exp_s = (expq.size() != 0) ? expq.pop_front() : prev_s;
      `CHK("state", exp_s, state)
      `CHK("internal_rst", exp_s <= 4'h1, internal_rst)
      `CHK("main_bias_en", exp_s >= 4'h3 && exp_s != 4'h9, main_bias_en)
      `CHK("pwrup_start", exp_s == 4'h5, pwrup_start)
      `CHK("pwrdn_start", exp_s == 4'h8, pwrdn_start)
      `CHK("periph_allow", exp_s == 4'h3 || exp_s == 4'h7, periph_allow)
      `CHK("flex_sequencer", {oosc_pkg::FLEX_SLOTS{exp_s == 4'h7}}, flex_sequencer)
    end
    prev_s = state;
  end
  //////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    if (fails == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // note states, one nibble each, first state in the top nibble
  task automatic owe(input logic [31:0] seq, input int n);
    for (int i = n - 1; i >= 0; i--) expq.push_back(seq[4*i+:4]);
  endtask
  // bounded wait until all notes are used, then a few idle cycles
  task automatic settle(input int bound);
    int t;
    t = 0;
    while (expq.size() != 0 && t < bound) begin
      @(posedge clk);
      t++;
    end
    if (expq.size() != 0) begin
      fails++;
      wrap_up();
    end else begin
      repeat (3) @(posedge clk);
    end
  endtask
  task automatic wr_code(input logic [1:0] c);
    @(posedge clk);
    software_reset_code <= c;
    software_reset_wr <= 1'b1;
    @(posedge clk);
    software_reset_wr <= 1'b0;
  endtask
  task automatic wake(input int m);
    @(posedge clk);
    if (m == 0) begin
      onkey_debounced <= 1'b0;
      onkey_n <= 1'b0;
    end else if (m == 1) charger_input <= 1'b1;
    else begin
      wr_code(oosc_pkg::SRST_COLD);
      #1 `CHK("wake_flag", 1'b1, wake_flag)
    end
  endtask
  task automatic quit(input int e);
    @(posedge clk);
    if (e == 0) otlo <= 1'b1;
    else if (e == 1) uvlo <= 1'b1;
    else if (e == 2) begin
      otlo <= 1'b1;
      uvlo <= 1'b1;
      ovlo <= 1'b1;
      wr_code(oosc_pkg::SRST_OFF);
    end else wr_code(e == 3 ? oosc_pkg::SRST_OFF : oosc_pkg::SRST_COLD);
  endtask
  //////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h30e5d9bf));
    {rst, onkey_n, onkey_debounced} = 3'h7;
    {supply_good, bias_enable, charger_input, software_reset_wr} = 4'h0;
    {hold_input, otlo, uvlo, ovlo} = 4'h0;
    software_reset_code = 2'h0;
    lat = 8'h00;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    supply_good <= 1'b1;
    owe(32'h12, 2);
    settle(400);
    bias_enable <= 1'b1;
    ovlo <= 1'b1;
    owe(32'h3, 1);
    settle(20);
    bias_enable <= 1'b0;
    owe(32'h2, 1);
    settle(20);
    ovlo <= 1'b0;
    charger_input <= 1'b1; // too short to count as a wake
    repeat (DB_CYC - 3) @(posedge clk);
    charger_input <= 1'b0;
    repeat (DB_CYC + 6) @(posedge clk);
    hold_input <= 1'b1;
    for (int k = 0; k < 5; k++) begin
      lat <= 8'($urandom_range(0, 6));
      wake(k % 3);
      owe(32'h4567, 4);
      settle(DB_CYC + 100);
      {onkey_debounced, onkey_n, charger_input} <= 3'h6;
      quit(k);
      owe(k == 4 ? 32'h8924567 : 32'h892, k == 4 ? 7 : 3);
      settle(200);
      {otlo, uvlo, ovlo} <= 3'h0;
    end
    supply_good <= 1'b0;
    owe(32'h0, 1);
    settle(20);
    supply_good <= 1'b1;
    owe(32'h12, 2);
    settle(400);
    hold_input <= 1'b0;
    wake(0);
    owe(32'h456892, 6);
    settle(HOLD_CYC + 100);
    wrap_up();
  end
endmodule
`default_nettype wire
